// ===== logic/aiis_core.sv
// ATA/ATAPI secondary interrupt flags, masks and interface pin status
// Assumes: MCU XDATA byte bus with one-cycle write strobe and combinational read data;
// autocommand sequencer supplies same-clock protocol event pulses.
// ATA pin levels are asynchronous and pass a two-flop synchroniser first.
`timescale 1ns/10ps
module aiis_core
    import aiis_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        reset,
    // MCU register port
    input  wire logic [15:0] mcu_addr,
    input  wire logic        mcu_wr,
    input  wire logic        mcu_rd,
    input  wire logic [7:0]  mcu_wdata,
    output logic      [7:0]  mcu_rdata,
    output logic             mcu_rd_hit,
    // Asynchronous ATA pins
    input  wire logic        ata_dmarq,
    input  wire logic        ata_dmack,
    input  wire logic        ata_intrq,
    input  wire logic        ata_busy,
    input  wire logic        ata_drq,
    // Sequencer side
    input  wire logic        atapi_mode,
    input  wire logic        nondata_cmd_cfg,
    input  wire logic        command_start_control,
    input  wire logic        cmd_issued,
    input  wire logic        data_seq_violation,
    input  wire logic        packet_seq_violation,
    input  wire logic        overrun_event,
    output logic             command_execute,
    // Interrupt toward primary register / vector logic
    output logic             secondary_source_pending,
    output logic             secondary_irq,
    output logic [7:0]       ata_primary_irq_enable,
    output logic [7:0]       irq_vector
);
    // ------------------------------------------------------------
    // State and local signals
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0]              pri_enable;
        logic [AIIS_NUM_SEC-1:0] sec_flags;
        logic [7:0]              sec_enable;
        logic                    overrun;
        logic                    exec;
    } aiis_state_t;

    aiis_state_t             state;
    aiis_state_t             next_state;
    aiis_pin_sync_if         pins ();
    logic [AIIS_NUM_SEC-1:0] sec_set;
    logic [AIIS_NUM_SEC-1:0] sec_clr;
    wire  [AIIS_NUM_SEC-1:0] sec_next;
    logic [7:0]              pin_status;
    logic                    wr_pri_enable;
    logic                    wr_sec_flags;
    logic                    wr_sec_enable;
    logic                    rd_pin_status;

    // ------------------------------------------------------------
    // Pin synchroniser
    // ------------------------------------------------------------
    aiis_pin_sync u_sync (
        .sys_clk    (sys_clk),
        .reset      (reset),
        .pins_async ({ata_drq, ata_busy, ata_intrq, ata_dmack, ata_dmarq}),
        .sync       (pins.producer)
    );

    // ------------------------------------------------------------
    // Register decode
    // ------------------------------------------------------------
    // One strobe per register; each acts on the rising edge
    always_comb begin
        wr_pri_enable = mcu_wr && (mcu_addr == AIIS_ADDR_PRI_ENABLE);
        wr_sec_flags  = mcu_wr && (mcu_addr == AIIS_ADDR_SEC_FLAGS);
        wr_sec_enable = mcu_wr && (mcu_addr == AIIS_ADDR_SEC_ENABLE);
        rd_pin_status = mcu_rd && (mcu_addr == AIIS_ADDR_PIN_STATUS);
    end

    // ------------------------------------------------------------
    // Event sources
    // ------------------------------------------------------------
    // Each source is a one-cycle pulse qualified by its condition
    always_comb begin
        sec_set = '0;
        sec_clr = '0;
        // Nondata command, yet the drive still requests data
        if (cmd_issued && nondata_cmd_cfg && pins.drive_drq) begin
            sec_set[AIIS_BIT_NONDATA] = 1'b1;
        end
        // Data phase protocol break, counted only in ATAPI mode
        if (atapi_mode && data_seq_violation) begin
            sec_set[AIIS_BIT_DSEQ] = 1'b1;
        end
        // Command packet protocol break, ATAPI mode only
        if (atapi_mode && packet_seq_violation) begin
            sec_set[AIIS_BIT_PSEQ] = 1'b1;
        end
        // Start strobe met a busy drive
        if (command_start_control && pins.drive_busy) begin
            sec_set[AIIS_BIT_BUSY] = 1'b1;
        end
        // Write-one-to-clear on the flag register
        if (wr_sec_flags) begin
            sec_clr = mcu_wdata[AIIS_NUM_SEC-1:0];
        end
    end

    // ------------------------------------------------------------
    // Per-flag update
    // ------------------------------------------------------------
    // Set wins over a same-cycle write-one clear, so no event is lost
    for (genvar g = 0; g < AIIS_NUM_SEC; g++) begin : g_flag
        assign sec_next[g] = sec_set[g] | (state.sec_flags[g] & ~sec_clr[g]);
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        next_state           = state;
        next_state.sec_flags = sec_next;
        if (wr_pri_enable) begin
            next_state.pri_enable = mcu_wdata;
        end
        if (wr_sec_enable) begin
            next_state.sec_enable = mcu_wdata;
        end
        // Overrun: read-to-clear, new event wins
        if (rd_pin_status) begin
            next_state.overrun = 1'b0;
        end
        if (overrun_event) begin
            next_state.overrun = 1'b1;
        end
        // Busy drive at start: sequencer is not told to run
        next_state.exec      = command_start_control & ~pins.drive_busy;
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------
    // Status byte
    // ------------------------------------------------------------
    // Overrun in its own bit, live pin mirror above, rest zero
    always_comb begin
        pin_status                   = AIIS_RST_BYTE;
        pin_status[AIIS_BIT_OVERRUN] = state.overrun;
        pin_status[AIIS_BIT_DMARQ]   = pins.dmarq;
        pin_status[AIIS_BIT_DMACK]   = pins.dmack;
        pin_status[AIIS_BIT_INTRQ]   = pins.intrq;
    end

    // ------------------------------------------------------------
    // Interrupt outputs
    // ------------------------------------------------------------
    // Summary ignores the mask; the interrupt line honours it
    assign secondary_source_pending = |state.sec_flags;
    assign secondary_irq            = |(state.sec_flags & state.sec_enable[AIIS_NUM_SEC-1:0]);
    // Vector only while an enabled secondary source is pending
    assign irq_vector               = secondary_irq ? AIIS_ATA_VECTOR : AIIS_RST_BYTE;
    assign ata_primary_irq_enable   = state.pri_enable;

    // ------------------------------------------------------------
    // Command start
    // ------------------------------------------------------------
    // Registered, one cycle after an accepted start strobe
    assign command_execute          = state.exec;

    // ------------------------------------------------------------
    // Register read data
    // ------------------------------------------------------------
    // Unmapped addresses read zero and drop the hit flag
    always_comb begin
        mcu_rdata  = AIIS_RST_BYTE;
        mcu_rd_hit = 1'b1;
        case (mcu_addr)
            AIIS_ADDR_PRI_ENABLE: begin
                mcu_rdata = state.pri_enable;
            end
            AIIS_ADDR_SEC_FLAGS: begin
                mcu_rdata[AIIS_NUM_SEC-1:0] = state.sec_flags;
            end
            AIIS_ADDR_SEC_ENABLE: begin
                mcu_rdata = state.sec_enable;
            end
            AIIS_ADDR_PIN_STATUS: begin
                mcu_rdata = pin_status;
            end
            default: begin
                mcu_rd_hit = 1'b0;
            end
        endcase
    end
endmodule : aiis_core

// ===== logic/aiis_pkg.sv
// Package: register map, field positions and reset values of the ATA interrupt/status block
// Assumes: 8-bit MCU data bus with 16-bit XDATA addresses
package aiis_pkg;
    localparam logic [15:0] AIIS_ADDR_PRI_ENABLE  = 16'hf0e7;
    localparam logic [15:0] AIIS_ADDR_SEC_FLAGS   = 16'hf0e8;
    localparam logic [15:0] AIIS_ADDR_SEC_ENABLE  = 16'hf0e9;
    localparam logic [15:0] AIIS_ADDR_PIN_STATUS  = 16'hf0ea;

    localparam int          AIIS_BIT_NONDATA      = 0;
    localparam int          AIIS_BIT_DSEQ         = 1;
    localparam int          AIIS_BIT_PSEQ         = 2;
    localparam int          AIIS_BIT_BUSY         = 3;
    localparam int          AIIS_NUM_SEC          = 4;

    localparam int          AIIS_BIT_OVERRUN      = 0;
    localparam int          AIIS_BIT_DMARQ        = 1;
    localparam int          AIIS_BIT_DMACK        = 2;
    localparam int          AIIS_BIT_INTRQ        = 3;

    localparam logic [7:0]  AIIS_RST_BYTE         = 8'h00;
    localparam logic [7:0]  AIIS_ATA_VECTOR       = 8'h48;
endpackage : aiis_pkg

// ===== logic/aiis_pin_sync_if.sv
// Interface: synchronised ATA pin levels from the pin synchroniser to the core
// Assumes: single sys_clk domain
`timescale 1ns/10ps
interface aiis_pin_sync_if;
    logic dmarq;
    logic dmack;
    logic intrq;
    logic drive_busy;
    logic drive_drq;
    modport producer (output dmarq, output dmack, output intrq, output drive_busy, output drive_drq);
    modport consumer (input dmarq, input dmack, input intrq, input drive_busy, input drive_drq);
endinterface : aiis_pin_sync_if

// ===== logic/aiis_pin_sync.sv
// Two-flop synchroniser for the asynchronous ATA pin levels
// Assumes: pins are asynchronous to sys_clk
`timescale 1ns/10ps
module aiis_pin_sync
    import aiis_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       reset,
    input  wire logic [4:0] pins_async,
    aiis_pin_sync_if.producer sync
);
    typedef struct packed {
        logic [4:0] stage1;
        logic [4:0] stage2;
    } aiis_sync_state_t;

    aiis_sync_state_t state;
    aiis_sync_state_t next_state;

    always_comb begin
        next_state        = state;
        next_state.stage1 = pins_async;
        next_state.stage2 = state.stage1;
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign sync.dmarq      = state.stage2[0];
    assign sync.dmack      = state.stage2[1];
    assign sync.intrq      = state.stage2[2];
    assign sync.drive_busy = state.stage2[3];
    assign sync.drive_drq  = state.stage2[4];
endmodule : aiis_pin_sync

// ===== tb/aiis_core_properties.sv
// Checker: timing properties on the aiis_core ports
// Assumes: bound into every aiis_core, one clock domain
`timescale 1ns/10ps
module aiis_core_properties
    import aiis_pkg::*;
(
    input wire logic        sys_clk,
    input wire logic        reset,
    input wire logic [15:0] mcu_addr,
    input wire logic [7:0]  mcu_rdata,
    input wire logic        ata_dmarq,
    input wire logic        ata_dmack,
    input wire logic        ata_intrq,
    input wire logic        ata_busy,
    input wire logic        atapi_mode,
    input wire logic        command_start_control,
    input wire logic        data_seq_violation,
    input wire logic        packet_seq_violation,
    input wire logic        command_execute,
    input wire logic        secondary_source_pending,
    input wire logic        secondary_irq,
    input wire logic [7:0]  irq_vector
);
    // ----
    // Properties
    // ----
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    sequence s_busy_start; ata_busy[*3] ##0 command_start_control; endsequence
    sequence s_idle_start; (!ata_busy)[*3] ##0 command_start_control; endsequence
    sequence s_pins_held; $stable({ata_dmarq, ata_dmack, ata_intrq})[*2]; endsequence
    AST_BUSY_FLAG: assert property (s_busy_start |=> secondary_source_pending && !command_execute)
        else $error("busy start not flagged or executed");
    AST_START_RUN: assert property (s_idle_start |=> command_execute)
        else $error("idle start not executed");
    AST_DSEQ: assert property (atapi_mode && data_seq_violation |=> secondary_source_pending)
        else $error("data sequence error not flagged");
    AST_PSEQ: assert property (atapi_mode && packet_seq_violation |=> secondary_source_pending)
        else $error("packet sequence error not flagged");
    AST_PEND: assert property (secondary_irq |-> secondary_source_pending)
        else $error("irq without pending summary");
    AST_VEC: assert property (irq_vector == (secondary_irq ? AIIS_ATA_VECTOR : 8'h00))
        else $error("vector mismatch");
    AST_RSV: assert property (mcu_addr == AIIS_ADDR_SEC_FLAGS |-> mcu_rdata[7:4] == 4'h0)
        else $error("reserved flag bits not zero");
    AST_PINS: assert property (s_pins_held ##0 mcu_addr == AIIS_ADDR_PIN_STATUS
        |-> mcu_rdata[3:1] == {ata_intrq, ata_dmack, ata_dmarq})
        else $error("pin status mismatch");
endmodule : aiis_core_properties
bind aiis_core aiis_core_properties u_props (.sys_clk, .reset, .mcu_addr, .mcu_rdata, .ata_dmarq, .ata_dmack,
    .ata_intrq, .ata_busy, .atapi_mode, .command_start_control, .data_seq_violation, .packet_seq_violation,
    .command_execute, .secondary_source_pending, .secondary_irq, .irq_vector);

// ===== tb/aiis_drive_model.sv
// Drive model: ATA pin levels {drq, busy, intrq, dmack, dmarq}
// Assumes: levels change on the falling edge of sys_clk, half a cycle from the sampling edge
`timescale 1ns/10ps
module aiis_drive_model (
    input  wire logic       sys_clk,
    input  wire logic [4:0] cmd,
    output logic      [4:0] pins = 5'h00
);
    always @(negedge sys_clk) pins <= cmd;
endmodule : aiis_drive_model

// ===== tb/ata_interface_interrupt_status_tb_top.sv
// Testbench: self-checking bench for the ATA interrupt/status block
// Assumes: aiis_core with the drive model on its ATA pins
`timescale 1ns/10ps
module ata_interface_interrupt_status_tb_top
    import aiis_pkg::*;
;
    // ----
    // Bench
    // ----
    logic        sys_clk = 1'b0, reset = 1'b1, mcu_wr = 1'b0, mcu_rd = 1'b0, atapi_mode = 1'b1;
    logic        nondata_cmd_cfg = 1'b1, command_start_control = 1'b0, cmd_issued = 1'b0;
    logic        data_seq_violation = 1'b0, packet_seq_violation = 1'b0, overrun_event = 1'b0;
    logic        mcu_rd_hit, command_execute, secondary_source_pending, secondary_irq;
    logic [15:0] mcu_addr = 16'h0000;
    logic [7:0]  mcu_wdata = 8'h00, mcu_rdata, ata_primary_irq_enable, irq_vector;
    logic [4:0]  pin_cmd = 5'h00;
    wire  [4:0]  pins;
    int          n_errors = 0, num_checks = 0;
    aiis_drive_model u_drive (.sys_clk, .cmd(pin_cmd), .pins);
    aiis_core DUT (.sys_clk, .reset, .mcu_addr, .mcu_wr, .mcu_rd, .mcu_wdata, .mcu_rdata, .mcu_rd_hit,
        .ata_dmarq(pins[0]), .ata_dmack(pins[1]), .ata_intrq(pins[2]), .ata_busy(pins[3]), .ata_drq(pins[4]),
        .atapi_mode, .nondata_cmd_cfg, .command_start_control, .cmd_issued, .data_seq_violation,
        .packet_seq_violation, .overrun_event, .command_execute, .secondary_source_pending, .secondary_irq,
        .ata_primary_irq_enable, .irq_vector);
    initial forever #2 sys_clk = ~sys_clk;
    task chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task wr(input logic [15:0] a, input logic [7:0] d);
        mcu_addr = a;
        mcu_wdata = d;
        mcu_wr = 1'b1;
        @(negedge sys_clk) mcu_wr = 1'b0;
        @(negedge sys_clk);
    endtask : wr
    task rd(input logic [15:0] a, input logic [7:0] e);
        mcu_addr = a;
        mcu_rd = 1'b1;
        #1 chk(mcu_rdata, e);
        chk({7'h0, mcu_rd_hit}, 8'h01);
        @(negedge sys_clk) mcu_rd = 1'b0;
        @(negedge sys_clk);
    endtask : rd
    task automatic pulse(ref logic s);
        s = 1'b1;
        @(negedge sys_clk) s = 1'b0;
    endtask : pulse
    task t_regs;
        wr(AIIS_ADDR_PRI_ENABLE, 8'ha5);
        rd(AIIS_ADDR_PRI_ENABLE, 8'ha5);
        chk(ata_primary_irq_enable, 8'ha5);
        wr(AIIS_ADDR_SEC_ENABLE, 8'h05);
        rd(AIIS_ADDR_SEC_ENABLE, 8'h05);
        wr(AIIS_ADDR_PIN_STATUS, 8'hff);
        rd(AIIS_ADDR_PIN_STATUS, 8'h00);
        mcu_addr = 16'hf0eb;
        #1 chk({7'h0, mcu_rd_hit}, 8'h00);
        $display("t_regs done");
    endtask : t_regs
    task t_events;
        for (int i = 0; i < AIIS_NUM_SEC; i++) begin
            pin_cmd = (i == 0) ? 5'h10 : (i == 3) ? 5'h08 : 5'h00;
            repeat (3) @(negedge sys_clk);
            case (i)
                0: pulse(cmd_issued);
                1: pulse(data_seq_violation);
                2: pulse(packet_seq_violation);
                default: pulse(command_start_control);
            endcase
            chk({7'h0, command_execute}, 8'h00);
            wr(AIIS_ADDR_SEC_FLAGS, ~(8'h01 << i));
            rd(AIIS_ADDR_SEC_FLAGS, 8'h01 << i);
            chk({6'h0, secondary_irq, secondary_source_pending}, {6'h0, ~i[0], 1'b1});
            chk(irq_vector, i[0] ? 8'h00 : AIIS_ATA_VECTOR);
            wr(AIIS_ADDR_SEC_FLAGS, 8'h01 << i);
            rd(AIIS_ADDR_SEC_FLAGS, 8'h00);
        end
        pin_cmd = 5'h00;
        repeat (3) @(negedge sys_clk);
        pulse(command_start_control);
        chk({7'h0, command_execute}, 8'h01);
        $display("t_events done");
    endtask : t_events
    task t_gating;
        atapi_mode = 1'b0;
        nondata_cmd_cfg = 1'b0;
        pin_cmd = 5'h10;
        repeat (3) @(negedge sys_clk);
        pulse(data_seq_violation);
        pulse(packet_seq_violation);
        pulse(cmd_issued);
        rd(AIIS_ADDR_SEC_FLAGS, 8'h00);
        chk({7'h0, secondary_source_pending}, 8'h00);
        atapi_mode = 1'b1;
        nondata_cmd_cfg = 1'b1;
        pin_cmd = 5'h00;
        pulse(data_seq_violation);
        @(negedge sys_clk);
        mcu_addr = AIIS_ADDR_SEC_FLAGS;
        mcu_wdata = 8'h02;
        mcu_wr = 1'b1;
        data_seq_violation = 1'b1;
        @(negedge sys_clk);
        mcu_wr = 1'b0;
        data_seq_violation = 1'b0;
        rd(AIIS_ADDR_SEC_FLAGS, 8'h02);
        wr(AIIS_ADDR_SEC_FLAGS, 8'h02);
        rd(AIIS_ADDR_SEC_FLAGS, 8'h00);
        $display("t_gating done");
    endtask : t_gating
    task t_status;
        for (int p = 1; p < 8; p += 3) begin
            pin_cmd = 5'(p);
            repeat (3) @(negedge sys_clk);
            rd(AIIS_ADDR_PIN_STATUS, 8'(p << 1));
        end
        overrun_event = 1'b1;
        mcu_addr = AIIS_ADDR_PIN_STATUS;
        mcu_rd = 1'b1;
        @(negedge sys_clk) overrun_event = 1'b0;
        rd(AIIS_ADDR_PIN_STATUS, 8'h0f);
        rd(AIIS_ADDR_PIN_STATUS, 8'h0e);
        $display("t_status done");
    endtask : t_status
    task end_sim;
        $display("checks=%0d errors=%0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : end_sim
    initial begin
        repeat (20) @(negedge sys_clk);
        reset = 1'b0;
        @(negedge sys_clk);
        t_regs;
        t_events;
        t_gating;
        t_status;
        end_sim;
    end
    initial begin
        #100000;
        n_errors++;
        end_sim;
    end
endmodule : ata_interface_interrupt_status_tb_top
